// file: design/asp_baud_timer.sv
// 8-bit auto-reload timer emitting a one-cycle overflow pulse
`timescale 1ns/1ps
module asp_baud_timer
    import asp_pkg::*;
#(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic en_i,
    // control
    input wire logic tick_i,
    input wire logic force_i,
    input wire logic [WIDTH-1:0] reload_i,
    // result
    output logic ovf_o
);
    logic [WIDTH-1:0] cnt_r;

    // count on tick, reload on overflow or forced reload
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r <= '0;
            ovf_o <= 1'b0;
        end else if (en_i) begin
            ovf_o <= 1'b0;
            if (force_i) begin
                cnt_r <= reload_i;
            end else if (tick_i) begin
                if (&cnt_r) begin
                    cnt_r <= reload_i;
                    ovf_o <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + 1'b1;
                end
            end
        end
    end
endmodule

// file: design/asp_serial_port.sv
// full-duplex serial port with 8/9-bit frames, apb registers, own baud timers
`timescale 1ns/1ps
module asp_serial_port
    import asp_pkg::*;
#(
    parameter int RELOAD_W = 8
) (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // baud clock sources
    input wire logic ext_osc_tick_i,
    input wire logic baud_timer_ext_input_i,
    // serial pins
    input wire logic serial_rx_pin_i,
    output logic serial_tx_pin_o,
    // interrupt request
    input wire logic irq_enable_i,
    output logic irq_o
);
    // =========================================
    // elaboration check
    if (RELOAD_W != DATA_BITS) begin : g_bad_width
        $error("reload width must be eight");
    end

    // =========================================
    // registers
    logic frame_mode_select_r, multiproc_filter_enable_r, rx_enable_bit_r;
    logic tx_ninth_bit_r, rx_ninth_bit_r, tx_done_flag_r, rx_done_flag_r;
    logic [7:0] serial_data_buffer_r;
    logic [RELOAD_W-1:0] baud_timer_reload_r;
    logic timer_run_r;
    logic [2:0] timer_src_r;
    logic [7:0] ctl_rd;
    logic wr_en, rd_en;
    logic tx_set, rx_load, rx_ninth_nxt;

    assign wr_en = psel_i && penable_i && pwrite_i;
    assign rd_en = psel_i && penable_i && !pwrite_i;
    assign ctl_rd = {frame_mode_select_r, 1'b1, multiproc_filter_enable_r, rx_enable_bit_r,
                     tx_ninth_bit_r, rx_ninth_bit_r, tx_done_flag_r, rx_done_flag_r};

    // address decode used by read and write paths
    function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
        hit = (a == r);
    endfunction

    // =========================================
    // control register with hardware-set done flags
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            frame_mode_select_r <= CTL_RESET[CTL_MODE];
            multiproc_filter_enable_r <= CTL_RESET[CTL_MCE];
            rx_enable_bit_r <= CTL_RESET[CTL_REN];
            tx_ninth_bit_r <= CTL_RESET[CTL_TB8];
            rx_ninth_bit_r <= CTL_RESET[CTL_RB8];
            tx_done_flag_r <= CTL_RESET[CTL_TI];
            rx_done_flag_r <= CTL_RESET[CTL_RI];
        end else if (ce_i) begin
            if (wr_en && hit(paddr_i, ASP_CTRL_ADDR)) begin
                frame_mode_select_r <= pwdata_i[CTL_MODE];
                multiproc_filter_enable_r <= pwdata_i[CTL_MCE];
                rx_enable_bit_r <= pwdata_i[CTL_REN];
                tx_ninth_bit_r <= pwdata_i[CTL_TB8];
                rx_ninth_bit_r <= pwdata_i[CTL_RB8];
                tx_done_flag_r <= pwdata_i[CTL_TI];
                rx_done_flag_r <= pwdata_i[CTL_RI];
            end
            // hardware set wins over a same-cycle clear
            if (tx_set) begin
                tx_done_flag_r <= 1'b1;
            end
            if (rx_load) begin
                rx_done_flag_r <= 1'b1;
                rx_ninth_bit_r <= rx_ninth_nxt;
            end
        end
    end

    // baud timer configuration
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            baud_timer_reload_r <= RELOAD_RESET;
            timer_run_r <= 1'b0;
            timer_src_r <= SRC_SYS;
        end else if (ce_i && wr_en && hit(paddr_i, ASP_BAUD_ADDR)) begin
            baud_timer_reload_r <= pwdata_i[RELOAD_W-1:0];
            timer_run_r <= pwdata_i[BAUD_RUN];
            timer_src_r <= pwdata_i[BAUD_SRC_LO +: 3];
        end
    end

    // =========================================
    // timer clock source selection
    logic [5:0] pre_cnt_r;
    logic [2:0] ext_cnt_r;
    logic pin_d_r;
    logic tick;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pre_cnt_r <= '0;
            ext_cnt_r <= '0;
            pin_d_r <= 1'b0;
        end else if (ce_i) begin
            pre_cnt_r <= (pre_cnt_r == 6'(DIV48_N - 1)) ? '0 : pre_cnt_r + 1'b1;
            if (ext_osc_tick_i) begin
                ext_cnt_r <= ext_cnt_r + 1'b1;
            end
            pin_d_r <= baud_timer_ext_input_i;
        end
    end

    // one-cycle tick from the selected source
    always_comb begin
        unique case (timer_src_r)
            SRC_SYS: tick = 1'b1;
            SRC_DIV4: tick = (pre_cnt_r[1:0] == 2'h3);
            SRC_DIV12: tick = (pre_cnt_r == 6'(DIV12_N - 1)) ||
                              (pre_cnt_r == 6'(2*DIV12_N - 1)) ||
                              (pre_cnt_r == 6'(3*DIV12_N - 1)) ||
                              (pre_cnt_r == 6'(DIV48_N - 1));
            SRC_DIV48: tick = (pre_cnt_r == 6'(DIV48_N - 1));
            SRC_EXT8: tick = ext_osc_tick_i && (ext_cnt_r == 3'(EXT8_N - 1));
            SRC_PIN: tick = pin_d_r && !baud_timer_ext_input_i;
            default: tick = 1'b0;
        endcase
    end

    // =========================================
    // tx and hidden rx timers
    logic tx_ovf, rx_ovf, rx_force;
    asp_baud_timer #(.WIDTH(RELOAD_W)) u_tx_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .en_i(ce_i),
        .tick_i(tick && timer_run_r),
        .force_i(1'b0),
        .reload_i(baud_timer_reload_r),
        .ovf_o(tx_ovf)
    );
    asp_baud_timer #(.WIDTH(RELOAD_W)) u_rx_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .en_i(ce_i),
        .tick_i(tick && timer_run_r),
        .force_i(rx_force),
        .reload_i(baud_timer_reload_r),
        .ovf_o(rx_ovf)
    );

    // =========================================
    // transmitter: two overflows per bit
    asp_state_t tx_st_r;
    logic [7:0] tx_shift_r;
    logic [2:0] tx_bit_r;
    logic tx_half_r, tx_pend_r, tx_nine_r;
    logic tx_bit_end;
    assign tx_bit_end = tx_ovf && tx_half_r;
    assign tx_set = tx_bit_end && ((tx_st_r == ST_DATA && tx_bit_r == 3'h7 &&
                    !tx_nine_r) || tx_st_r == ST_NINTH);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_st_r <= ST_IDLE;
            tx_shift_r <= '0;
            tx_bit_r <= '0;
            tx_half_r <= 1'b0;
            tx_pend_r <= 1'b0;
            tx_nine_r <= 1'b0;
            serial_tx_pin_o <= 1'b1;
        end else if (ce_i) begin
            if (wr_en && hit(paddr_i, ASP_DATA_ADDR)) begin
                tx_shift_r <= pwdata_i[7:0];
                tx_pend_r <= 1'b1;
            end
            if (tx_ovf) begin
                tx_half_r <= !tx_half_r;
            end
            unique case (tx_st_r)
                ST_IDLE: begin
                    if (tx_pend_r && tx_bit_end) begin
                        tx_pend_r <= 1'b0;
                        tx_nine_r <= frame_mode_select_r;
                        serial_tx_pin_o <= 1'b0;
                        tx_st_r <= ST_START;
                    end
                end
                ST_START: begin
                    if (tx_bit_end) begin
                        serial_tx_pin_o <= tx_shift_r[0];
                        tx_bit_r <= '0;
                        tx_st_r <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (tx_bit_end) begin
                        if (tx_bit_r == 3'h7) begin
                            serial_tx_pin_o <= tx_nine_r ? tx_ninth_bit_r : 1'b1;
                            tx_st_r <= tx_nine_r ? ST_NINTH : ST_STOP;
                        end else begin
                            serial_tx_pin_o <= tx_shift_r[3'(tx_bit_r + 3'h1)];
                            tx_bit_r <= tx_bit_r + 1'b1;
                        end
                    end
                end
                ST_NINTH: begin
                    if (tx_bit_end) begin
                        serial_tx_pin_o <= 1'b1;
                        tx_st_r <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    if (tx_bit_end) begin
                        tx_st_r <= ST_IDLE;
                    end
                end
                default: tx_st_r <= ST_IDLE;
            endcase
        end
    end

    // =========================================
    // receiver: sample mid-bit, overflow pairs from forced reload
    asp_state_t rx_st_r;
    logic [7:0] rx_shift_r;
    logic [2:0] rx_bit_r;
    logic rx_half_r, rx_prev_r, rx_nine_r, rx_b9_r;
    logic rx_mid, rx_end, rx_ok;
    assign rx_force = (rx_st_r == ST_IDLE) && rx_enable_bit_r && timer_run_r &&
                      rx_prev_r && !serial_rx_pin_i;
    assign rx_mid = rx_ovf && !rx_half_r;
    assign rx_end = rx_ovf && rx_half_r;
    // stop bit in 8-bit mode, ninth bit in 9-bit mode gates the filter
    assign rx_ninth_nxt = rx_nine_r ? rx_b9_r : serial_rx_pin_i;
    assign rx_ok = !rx_done_flag_r && (!multiproc_filter_enable_r || rx_ninth_nxt);
    assign rx_load = (rx_st_r == ST_STOP) && rx_mid && rx_ok;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_st_r <= ST_IDLE;
            rx_shift_r <= '0;
            rx_bit_r <= '0;
            rx_half_r <= 1'b0;
            rx_prev_r <= 1'b1;
            rx_nine_r <= 1'b0;
            rx_b9_r <= 1'b0;
        end else if (ce_i) begin
            rx_prev_r <= serial_rx_pin_i;
            if (rx_force) begin
                rx_half_r <= 1'b0;
            end else if (rx_ovf) begin
                rx_half_r <= !rx_half_r;
            end
            unique case (rx_st_r)
                ST_IDLE: begin
                    if (rx_force) begin
                        rx_nine_r <= frame_mode_select_r;
                        rx_st_r <= ST_START;
                    end
                end
                ST_START: begin
                    if (rx_mid) begin
                        rx_bit_r <= '0;
                        rx_st_r <= serial_rx_pin_i ? ST_IDLE : ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (rx_mid) begin
                        rx_shift_r <= {serial_rx_pin_i, rx_shift_r[7:1]};
                        rx_bit_r <= rx_bit_r + 1'b1;
                        if (rx_bit_r == 3'h7) begin
                            rx_st_r <= rx_nine_r ? ST_NINTH : ST_STOP;
                        end
                    end
                end
                ST_NINTH: begin
                    if (rx_mid) begin
                        rx_b9_r <= serial_rx_pin_i;
                        rx_st_r <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    if (rx_mid) begin
                        rx_st_r <= ST_IDLE;
                    end
                end
                default: rx_st_r <= ST_IDLE;
            endcase
        end
    end

    // receive buffer, loaded only when conditions hold
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            serial_data_buffer_r <= '0;
        end else if (ce_i && rx_load) begin
            serial_data_buffer_r <= rx_shift_r;
        end
    end

    // =========================================
    // apb read data, zero wait states
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            prdata_o <= '0;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end else if (ce_i) begin
            pready_o <= psel_i && !penable_i;
            pslverr_o <= psel_i && !penable_i && !(hit(paddr_i, ASP_CTRL_ADDR) ||
                         hit(paddr_i, ASP_DATA_ADDR) || hit(paddr_i, ASP_BAUD_ADDR) ||
                         hit(paddr_i, ASP_STAT_ADDR));
            prdata_o <= '0;
            if (psel_i && !penable_i && !pwrite_i) begin
                if (hit(paddr_i, ASP_CTRL_ADDR)) begin
                    prdata_o <= {24'h000000, ctl_rd};
                end else if (hit(paddr_i, ASP_DATA_ADDR)) begin
                    prdata_o <= {24'h000000, serial_data_buffer_r};
                end else if (hit(paddr_i, ASP_BAUD_ADDR)) begin
                    prdata_o <= {20'h00000, timer_src_r, timer_run_r, baud_timer_reload_r};
                end else if (hit(paddr_i, ASP_STAT_ADDR)) begin
                    prdata_o <= {26'h0000000, tx_pend_r, tx_st_r != ST_IDLE,
                                 rx_st_r != ST_IDLE, rx_nine_r, rx_b9_r, tx_half_r};
                end
            end
        end
    end

    // interrupt on either done flag
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else if (ce_i) begin
            irq_o <= irq_enable_i && (tx_done_flag_r || rx_done_flag_r);
        end
    end
endmodule

// file: shared/asp_pkg.sv
// constants and types shared by the dual-mode serial port
package asp_pkg;
    // =========================================
    // register map (byte addresses on apb)
    localparam logic [11:0] ASP_CTRL_ADDR = 12'h000;
    localparam logic [11:0] ASP_DATA_ADDR = 12'h004;
    localparam logic [11:0] ASP_BAUD_ADDR = 12'h008;
    localparam logic [11:0] ASP_STAT_ADDR = 12'h00C;
    // =========================================
    // control register field positions
    localparam int CTL_MODE = 7;
    localparam int CTL_ONE = 6;
    localparam int CTL_MCE = 5;
    localparam int CTL_REN = 4;
    localparam int CTL_TB8 = 3;
    localparam int CTL_RB8 = 2;
    localparam int CTL_TI = 1;
    localparam int CTL_RI = 0;
    localparam logic [7:0] CTL_RESET = 8'h40;
    // =========================================
    // baud register fields: reload [7:0], run [8], source [11:9]
    localparam int BAUD_RUN = 8;
    localparam int BAUD_SRC_LO = 9;
    localparam logic [7:0] RELOAD_RESET = 8'h00;
    // =========================================
    // timer clock sources
    localparam logic [2:0] SRC_SYS = 3'h0;
    localparam logic [2:0] SRC_DIV4 = 3'h1;
    localparam logic [2:0] SRC_DIV12 = 3'h2;
    localparam logic [2:0] SRC_DIV48 = 3'h3;
    localparam logic [2:0] SRC_EXT8 = 3'h4;
    localparam logic [2:0] SRC_PIN = 3'h5;
    localparam int DIV4_N = 4;
    localparam int DIV12_N = 12;
    localparam int DIV48_N = 48;
    localparam int EXT8_N = 8;
    // =========================================
    // frame geometry
    localparam int DATA_BITS = 8;
    localparam int TICKS_PER_BIT = 2;
    // =========================================
    // shifter states
    typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_NINTH, ST_STOP} asp_state_t;
endpackage

// file: sim/asp_props.sv
// checker for bus answers, interrupt level and line framing of the port
`timescale 1ns/1ps
module asp_props
    import asp_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // apb
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // pins
    input wire logic serial_tx_pin_o,
    input wire logic irq_enable_i,
    input wire logic irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // address decode and control write strobe
    logic mapped;
    logic ctl_wr;
    assign mapped = paddr_i inside {ASP_CTRL_ADDR, ASP_DATA_ADDR, ASP_BAUD_ADDR, ASP_STAT_ADDR};
    assign ctl_wr = psel_i && penable_i && pwrite_i && paddr_i == ASP_CTRL_ADDR;
    // ========================================
    // assertions
    a_setup_answer: assert property (psel_i && !penable_i && ce_i |=> pready_o)
        else $error("no answer after setup");
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("answer held too long");
    a_unmapped_err: assert property (pready_o && !mapped |-> pslverr_o && prdata_o == 0)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (pready_o && mapped && !pwrite_i |-> !pslverr_o)
        else $error("mapped read refused");
    a_ctrl_one: assert property (pready_o && !pwrite_i && paddr_i == ASP_CTRL_ADDR |-> prdata_o[6])
        else $error("control bit six not one");
    a_data_upper: assert property (pready_o && paddr_i == ASP_DATA_ADDR |-> prdata_o[31:8] == 0)
        else $error("data read upper bits set");
    a_irq_masked: assert property (!$past(irq_enable_i) && $past(ce_i) |-> !irq_o)
        else $error("irq while disabled");
    a_irq_holds: assert property (irq_o && irq_enable_i && !ctl_wr && !$past(ctl_wr) |=> irq_o)
        else $error("irq dropped without software");
    a_tx_start: assert property ($fell(serial_tx_pin_o) |=> !serial_tx_pin_o)
        else $error("start bit too short");
endmodule
bind asp_serial_port asp_props u_props (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .serial_tx_pin_o(serial_tx_pin_o), .irq_enable_i(irq_enable_i), .irq_o(irq_o));

// file: sim/asp_remote_node.sv
// remote serial node: sends frames to the port and captures its frames
`timescale 1ns/1ps
module asp_remote_node (
    // clock and line settings
    input wire logic clk_i,
    input wire logic [15:0] bit_cyc_i,
    input wire logic nine_i,
    // serial lines
    input wire logic line_in_i,
    output logic line_out_o
);
    // last frame seen from the port
    logic [7:0] got_byte;
    logic got_ninth;
    logic got_stop;
    int got_cnt = 0;
    initial line_out_o = 1'h1;
    // holds one bit for a whole bit time
    task automatic put_bit(input logic b);
        line_out_o <= b;
        repeat (bit_cyc_i) @(posedge clk_i);
    endtask
    // start, lsb-first data, optional ninth, stop, then idle high
    task automatic send(input logic [7:0] d, input logic n9, input logic stp);
        @(posedge clk_i);
        put_bit(1'h0);
        for (int i = 0; i < 8; i++) put_bit(d[i]);
        if (nine_i) put_bit(n9);
        put_bit(stp);
        line_out_o <= 1'h1;
    endtask
    // a one-cycle low pulse that is no start bit
    task automatic glitch();
        @(posedge clk_i);
        line_out_o <= 1'h0;
        @(posedge clk_i);
        line_out_o <= 1'h1;
    endtask
    // samples each bit in the middle of its bit time
    always begin
        @(negedge line_in_i);
        repeat (bit_cyc_i / 2) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (bit_cyc_i) @(posedge clk_i);
            got_byte[i] = line_in_i;
        end
        if (nine_i) begin
            repeat (bit_cyc_i) @(posedge clk_i);
            got_ninth = line_in_i;
        end
        repeat (bit_cyc_i) @(posedge clk_i);
        got_stop = line_in_i;
        got_cnt++;
    end
endmodule

// file: sim/test_async_serial_port_dual_mode.sv
// self-checking bench for the dual-mode serial port
`timescale 1ns/1ps
module test_async_serial_port_dual_mode;
    import asp_pkg::*;
    // ========================================
    // stimulus and observed signals
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o, q;
    logic pready_o, pslverr_o, serial_tx_pin_o, irq_o, rx_line, e;
    logic ext_tick = 1'h0, ext_pin = 1'h1, irq_en = 1'h1, nine = 1'h0, ce = 1'h1;
    logic [15:0] bit_cyc = 16'h0004;
    logic [1:0] div_cnt = 2'h0;
    int n_mismatch = 0;
    int comparisons = 0;
    always #2.5 clk_i = ~clk_i;
    // oscillator tick every third cycle, timer pin falls every second
    always @(posedge clk_i) begin
        div_cnt <= (div_cnt == 2'h2) ? 2'h0 : div_cnt + 2'h1;
        ext_tick <= (div_cnt == 2'h2);
        ext_pin <= ~ext_pin;
    end
    asp_serial_port dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .ext_osc_tick_i(ext_tick), .baud_timer_ext_input_i(ext_pin),
        .serial_rx_pin_i(rx_line), .serial_tx_pin_o(serial_tx_pin_o),
        .irq_enable_i(irq_en), .irq_o(irq_o));
    asp_remote_node node_u (.clk_i(clk_i), .bit_cyc_i(bit_cyc), .nine_i(nine),
        .line_in_i(serial_tx_pin_o), .line_out_o(rx_line));
    // ========================================
    // bus and compare helpers
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        psel_i <= 1'h1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'h1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'h1);
        chk("access cycles", 32'h1, 32'(n));
        q = prdata_o;
        e = pslverr_o;
        psel_i <= 1'h0;
        penable_i <= 1'h0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x, input string nm);
        apb(1'h0, a, 32'h0);
        chk(nm, x, q);
    endtask
    task automatic ctl(input logic [7:0] v);
        apb(1'h1, ASP_CTRL_ADDR, {24'h0, v});
    endtask
    task automatic wait_flag(input int b);
        int n;
        n = 0;
        do begin
            apb(1'h0, ASP_CTRL_ADDR, 32'h0);
            n++;
        end while (q[b] !== 1'h1 && n < 3000);
        chk("flag wait", 32'h1, {31'h0, q[b]});
    endtask
    // ========================================
    // scenarios
    task automatic t_regs();
        rd(ASP_CTRL_ADDR, 32'h40, "ctrl reset");
        rd(ASP_DATA_ADDR, 32'h0, "rx buffer reset");
        rd(ASP_STAT_ADDR, 32'h0, "status idle");
        apb(1'h0, 12'h010, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, e});
        apb(1'h1, ASP_BAUD_ADDR, 32'h1FE);
        rd(ASP_BAUD_ADDR, 32'h1FE, "baud");
    endtask
    task automatic t_tx(input logic m, input logic [7:0] d);
        int c;
        c = node_u.got_cnt;
        nine = m;
        ctl({m, 3'h4, m, 3'h0});
        apb(1'h1, ASP_DATA_ADDR, {24'h0, d});
        rd(ASP_DATA_ADDR, 32'h0, "data reads rx");
        wait_flag(CTL_TI);
        chk("irq on tx done", 32'h1, {31'h0, irq_o});
        repeat (100) if (node_u.got_cnt == c) @(posedge clk_i);
        chk("frames", c + 1, node_u.got_cnt);
        chk("tx byte", {24'h0, d}, {24'h0, node_u.got_byte});
        chk("tx stop", 32'h1, {31'h0, node_u.got_stop});
        if (m) chk("tx ninth", 32'h1, {31'h0, node_u.got_ninth});
    endtask
    task automatic t_flags();
        ctl(8'h43);
        rd(ASP_CTRL_ADDR, 32'h43, "flags set");
        chk("irq raised", 32'h1, {31'h0, irq_o});
        // clock enable low freezes the interrupt output
        ce <= 1'h0;
        irq_en <= 1'h0;
        repeat (4) @(posedge clk_i);
        chk("irq frozen", 32'h1, {31'h0, irq_o});
        ce <= 1'h1;
        rd(ASP_CTRL_ADDR, 32'h43, "flags kept");
        chk("irq masked", 32'h0, {31'h0, irq_o});
        irq_en <= 1'h1;
        ctl(8'h40);
        rd(ASP_CTRL_ADDR, 32'h40, "flags cleared");
        chk("irq cleared", 32'h0, {31'h0, irq_o});
    endtask
    task automatic t_rx8();
        nine = 1'h0;
        ctl(8'h10);
        node_u.send(8'h5A, 1'h0, 1'h1);
        wait_flag(CTL_RI);
        rd(ASP_DATA_ADDR, 32'h5A, "rx byte");
        rd(ASP_CTRL_ADDR, 32'h55, "stop in ninth");
        node_u.send(8'hC3, 1'h0, 1'h1);
        rd(ASP_DATA_ADDR, 32'h5A, "overrun keeps");
        ctl(8'h34);
        node_u.send(8'h77, 1'h0, 1'h0);
        rd(ASP_CTRL_ADDR, 32'h74, "bad stop no load");
        rd(ASP_DATA_ADDR, 32'h5A, "bad stop keeps");
        ctl(8'h00);
        node_u.send(8'h12, 1'h0, 1'h1);
        rd(ASP_CTRL_ADDR, 32'h40, "receiver off");
    endtask
    task automatic t_rx9();
        nine = 1'h1;
        ctl(8'hB0);
        node_u.send(8'h42, 1'h0, 1'h1);
        rd(ASP_CTRL_ADDR, 32'hF0, "data filtered");
        node_u.send(8'h42, 1'h1, 1'h0);
        wait_flag(CTL_RI);
        rd(ASP_CTRL_ADDR, 32'hF5, "address ninth");
        fork
            node_u.send(8'h99, 1'h0, 1'h1);
        join_none
        rd(ASP_DATA_ADDR, 32'h42, "own address");
        ctl(8'h94);
        wait_flag(CTL_RI);
        rd(ASP_DATA_ADDR, 32'h99, "following byte");
        rd(ASP_CTRL_ADDR, 32'hD1, "data ninth zero");
        wait fork;
        ctl(8'hB0);
        node_u.send(8'h55, 1'h0, 1'h1);
        rd(ASP_CTRL_ADDR, 32'hF0, "message over");
    endtask
    task automatic t_glitch();
        nine = 1'h0;
        ctl(8'h10);
        node_u.glitch();
        repeat (bit_cyc * 11) @(posedge clk_i);
        rd(ASP_CTRL_ADDR, 32'h50, "false start");
        node_u.send(8'h34, 1'h0, 1'h1);
        wait_flag(CTL_RI);
        rd(ASP_DATA_ADDR, 32'h34, "after false start");
    endtask
    task automatic t_src();
        int tick[6] = '{1, 4, 12, 48, 24, 2};
        int len;
        ctl(8'h40);
        for (int s = 0; s < 6; s++) begin
            bit_cyc = 16'(2 * tick[s]);
            apb(1'h1, ASP_BAUD_ADDR, {20'h0, 3'(s), 9'h1FF});
            apb(1'h1, ASP_DATA_ADDR, 32'hFF);
            len = 0;
            while (serial_tx_pin_o !== 1'h0 && len < 400) begin
                @(posedge clk_i);
                len++;
            end
            len = 0;
            while (serial_tx_pin_o === 1'h0 && len < 400) begin
                @(posedge clk_i);
                len++;
            end
            chk("start bit cycles", 32'(2 * tick[s]), 32'(len));
            wait_flag(CTL_TI);
            ctl(8'h40);
        end
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'h0;
        t_regs();
        t_tx(1'h0, 8'hA5);
        t_tx(1'h1, 8'h3C);
        t_flags();
        t_rx8();
        t_rx9();
        t_glitch();
        t_src();
        test_done();
    end
    // watchdog against a hang
    initial begin
        repeat (40000) @(posedge clk_i);
        n_mismatch++;
        test_done();
    end
endmodule
